// [logic/adc_output_demux_control.sv]
`timescale 1ns/1ns
// What this block does
// - Sample reaches bank stage after fixed latency
// - Low three bits latched one cycle later
// - At most three bits resolved per stage
// - Gray folder codes decoded by xor cells
// - Output words are straight binary, monotonic
// - Two mode pins choose output mode
// - Single mode uses first bank only
// - Interleaved mode alternates banks each sample
// - Parallel mode delays first bank one sample
// - Half rate derived by dividing by two
// - Divider phase picks the receiving bank
// - Differential reset phase-aligns the divider
// - Strobe latches data or shows bank
// - Power-down tri-states all data and strobe
module adc_output_demux_control
    import adc_demux_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Folder results, gray coded
    input wire logic [adc_demux_pkg::MSB_W-1:0] fold_msb_gray,
    input wire logic [adc_demux_pkg::MID_W-1:0] fold_mid_gray,
    input wire logic [adc_demux_pkg::LSB_W-1:0] fold_lsb_gray,
    // Static pins
    input wire logic output_mode_sel_first,
    input wire logic output_mode_sel_second,
    input wire logic power_down_pin,
    input wire logic sync_reset_p,
    input wire logic sync_reset_n,
    // First bank
    output logic [adc_demux_pkg::WORD_W-1:0] first_bank_bus,
    output logic first_bank_oe,
    // Second bank
    output logic [adc_demux_pkg::WORD_W-1:0] second_bank_bus,
    output logic second_bank_oe,
    // Differential strobe
    output logic output_strobe_p,
    output logic output_strobe_n,
    output logic output_strobe_oe,
    // AXI4-Lite write address
    input wire logic [adc_demux_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [adc_demux_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import adc_demux_pkg::*;

    logic [MSB_W-1:0] msb_bin;
    logic [MSB_W-1:0] msb_bin_q;
    logic [MID_W-1:0] mid_gray_q;
    logic [MID_W-1:0] mid_bin;
    logic [MSB_W+MID_W-1:0] upper_bin_q;
    logic [LSB_W-1:0] lsb_gray_q;
    logic [LSB_W-1:0] lsb_bin;
    logic [WORD_W-1:0] word_q;
    logic [WORD_W-1:0] hold_q;
    logic [WORD_W-1:0] bank_a_q;
    logic [WORD_W-1:0] bank_b_q;
    logic strobe_q;
    logic phase;
    logic resync;
    logic resync_pulse_q;
    logic soft_pd_q;
    logic powered_down;
    out_mode_e mode;

    // Stage 1: three top bits from the coarse folder
    gray_slice #(.W(MSB_W)) u_msb_slice (
        .gray(fold_msb_gray),
        .upper_bit(1'b0),
        .bin(msb_bin)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msb_bin_q <= '0;
            mid_gray_q <= '0;
        end else begin
            msb_bin_q <= msb_bin;
            mid_gray_q <= fold_mid_gray;
        end
    end

    // Stage 2: two middle bits; low bits caught one cycle after the top bits
    gray_slice #(.W(MID_W)) u_mid_slice (
        .gray(mid_gray_q),
        .upper_bit(msb_bin_q[0]),
        .bin(mid_bin)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper_bin_q <= '0;
            lsb_gray_q <= '0;
        end else begin
            upper_bin_q <= {msb_bin_q, mid_bin};
            lsb_gray_q <= fold_lsb_gray;
        end
    end

    // Stage 3: three low bits, completing the straight binary word
    gray_slice #(.W(LSB_W)) u_lsb_slice (
        .gray(lsb_gray_q),
        .upper_bit(upper_bin_q[0]),
        .bin(lsb_bin)
    );

    // Word is ready at the bank stage LATENCY_CYCLES edges after the top bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_q <= WORD_RESET;
        end else begin
            word_q <= {upper_bin_q, lsb_bin};
        end
    end

    // Mode pins are read live; changing them mid-run needs a resync
    always_comb begin
        if (output_mode_sel_first) begin
            mode = MODE_SINGLE;
        end else if (output_mode_sel_second) begin
            mode = MODE_INTERLEAVED;
        end else begin
            mode = MODE_PARALLEL;
        end
    end

    // Differential reset counts only when the pair is driven p high, n low
    assign resync = (sync_reset_p & ~sync_reset_n) | resync_pulse_q;

    half_rate_divider u_divider (
        .aclk(aclk),
        .aresetn(aresetn),
        .resync(resync),
        .phase(phase)
    );

    // Bank routing; single mode relies on the source keeping to its rate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_a_q <= WORD_RESET;
            bank_b_q <= WORD_RESET;
            hold_q <= WORD_RESET;
        end else begin
            case (mode)
                MODE_SINGLE: begin
                    bank_a_q <= word_q;
                end
                MODE_INTERLEAVED: begin
                    if (!phase) begin
                        bank_a_q <= word_q;
                    end else begin
                        bank_b_q <= word_q;
                    end
                end
                default: begin
                    if (!phase) begin
                        hold_q <= word_q;
                    end else begin
                        bank_a_q <= hold_q;
                        bank_b_q <= word_q;
                    end
                end
            endcase
        end
    end

    // Strobe toggles per sample in single mode, marks bank in interleaved mode and the new pair in parallel mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= phase;
        end
    end

    assign powered_down = power_down_pin | soft_pd_q;
    assign first_bank_bus = bank_a_q;
    assign second_bank_bus = bank_b_q;
    assign output_strobe_p = strobe_q;
    assign output_strobe_n = ~strobe_q;
    assign first_bank_oe = ~powered_down;
    assign second_bank_oe = ~powered_down;
    assign output_strobe_oe = ~powered_down;

    // AXI4-Lite slave: address and data taken in either order
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_write;

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign do_write = aw_held_q & w_held_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    // Control writes; the resync bit is a one-cycle pulse, never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_pd_q <= CTRL_SOFT_PD_RESET;
            resync_pulse_q <= 1'b0;
        end else begin
            resync_pulse_q <= 1'b0;
            if (do_write && awaddr_q == CTRL_OFFSET && wstrb_q[0]) begin
                soft_pd_q <= wdata_q[CTRL_SOFT_PD_BIT];
                resync_pulse_q <= wdata_q[CTRL_RESYNC_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            if (awaddr_q == CTRL_OFFSET) begin
                bresp_q <= RESP_OKAY;
            end else if (awaddr_q == STATUS_OFFSET || awaddr_q == SAMPLE_OFFSET) begin
                bresp_q <= RESP_OKAY;
            end else begin
                bresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
            if (s_axi_araddr == CTRL_OFFSET) begin
                rdata_q[CTRL_SOFT_PD_BIT] <= soft_pd_q;
            end else if (s_axi_araddr == STATUS_OFFSET) begin
                rdata_q[STATUS_MODE_LSB+:2] <= mode;
                rdata_q[STATUS_PHASE_BIT] <= phase;
                rdata_q[STATUS_PD_BIT] <= powered_down;
            end else if (s_axi_araddr == SAMPLE_OFFSET) begin
                rdata_q[WORD_W-1:0] <= word_q;
            end else begin
                rresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule // adc_output_demux_control

// [logic/adc_demux_pkg.sv]
package adc_demux_pkg;
    // Sample word and decode slice widths
    localparam int WORD_W = 8;
    localparam int MSB_W = 3;
    localparam int MID_W = 2;
    localparam int LSB_W = 3;
    // Latency to the bank selection stage, in half sample cycles
    localparam int LATENCY_HALF_CYCLES = 5;
    // Least time rounds up to whole aclk cycles
    localparam int LATENCY_CYCLES = (LATENCY_HALF_CYCLES + 1) / 2;

    // Output modes, coded as {first select, second select}
    typedef enum logic [1:0] {
        MODE_PARALLEL = 2'b00,
        MODE_INTERLEAVED = 2'b01,
        MODE_SINGLE = 2'b10
    } out_mode_e;

    // Register map, byte addresses
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] SAMPLE_OFFSET = 4'h8;
    localparam int ADDR_W = 4;

    // Control fields
    localparam int CTRL_SOFT_PD_BIT = 0;
    localparam int CTRL_RESYNC_BIT = 1;
    localparam logic CTRL_SOFT_PD_RESET = 1'b0;

    // Status fields
    localparam int STATUS_MODE_LSB = 0;
    localparam int STATUS_PHASE_BIT = 2;
    localparam int STATUS_PD_BIT = 3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
endpackage

// [logic/gray_slice.sv]
`timescale 1ns/1ns
// Gray to binary over one slice, chained from the next more significant bit
module gray_slice #(
    parameter int W = 3
) (
    // Slice input
    input wire logic [W-1:0] gray,
    input wire logic upper_bit,
    // Slice output
    output logic [W-1:0] bin
);
    always_comb begin
        bin[W-1] = upper_bit ^ gray[W-1];
        for (int i = W - 2; i >= 0; i--) begin
            bin[i] = bin[i+1] ^ gray[i];
        end
    end
endmodule // gray_slice

// [logic/half_rate_divider.sv]
`timescale 1ns/1ns
// Divide by two of the sample clock, as a phase bit with resync
module half_rate_divider (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic resync,
    // State
    output logic phase
);
    logic phase_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || resync) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    assign phase = phase_q;
endmodule // half_rate_divider

// [test/adc_demux_chk.sv]
`timescale 1ns/1ns
module adc_demux_chk
    import adc_demux_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins
    input wire logic output_mode_sel_first,
    input wire logic output_mode_sel_second,
    input wire logic power_down_pin,
    input wire logic sync_reset_p,
    input wire logic sync_reset_n,
    // Outputs
    input wire logic [adc_demux_pkg::WORD_W-1:0] first_bank_bus,
    input wire logic [adc_demux_pkg::WORD_W-1:0] second_bank_bus,
    input wire logic first_bank_oe,
    input wire logic second_bank_oe,
    input wire logic output_strobe_p,
    input wire logic output_strobe_n,
    input wire logic output_strobe_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic rs = sync_reset_p && !sync_reset_n;
    wire logic par = !output_mode_sel_first && !output_mode_sel_second;
    wire logic il = !output_mode_sel_first && output_mode_sel_second;

    chk_pd_tristate:
    assert property (power_down_pin |-> !first_bank_oe && !second_bank_oe && !output_strobe_oe)
        else $error("outputs driven in power-down");
    chk_strobe_pair:
    assert property (output_strobe_n == !output_strobe_p)
        else $error("strobe pair not complementary");
    chk_single_bank:
    assert property (output_mode_sel_first |=> $stable(second_bank_bus))
        else $error("second bank moved in single mode");
    chk_divider_toggle:
    assert property (aresetn && !rs |-> ##2 output_strobe_p != $past(output_strobe_p))
        else $error("half-rate phase did not alternate");
    chk_resync_phase:
    assert property (rs |-> ##2 !output_strobe_p)
        else $error("resync did not zero the phase");
    chk_reset_phase:
    assert property ($rose(aresetn) |-> ##1 !output_strobe_p)
        else $error("first cycle after reset not on first bank");
    chk_parallel_pair:
    assert property (par |=> output_strobe_p || ($stable(first_bank_bus) && $stable(second_bank_bus)))
        else $error("parallel bank moved on hold phase");
    chk_interleave_bank:
    assert property (il |=> (output_strobe_p ? $stable(first_bank_bus) : $stable(second_bank_bus)))
        else $error("interleaved sample went to wrong bank");
endmodule // adc_demux_chk

// [test/capture_rx_model.sv]
`timescale 1ns/1ns
// Receiver pads; a released line shows the inverse of its last level
module capture_rx_model (
    // Clock
    input wire logic aclk,
    // Device pins
    input wire logic [7:0] bank_a,
    input wire logic [7:0] bank_b,
    input wire logic strobe,
    input wire logic oe,
    // Levels seen on the wires
    output logic [7:0] lvl_a,
    output logic [7:0] lvl_b,
    output logic lvl_s
);
    logic [16:0] last_q;
    always_ff @(posedge aclk) begin
        if (oe) begin
            last_q <= {bank_a, bank_b, strobe};
        end
    end
    // Strobe used as bank indicator
    assign {lvl_a, lvl_b, lvl_s} = oe ? {bank_a, bank_b, strobe} : ~last_q;
endmodule // capture_rx_model

// [test/adc_output_demux_control_test.sv]
`timescale 1ns/1ns
module adc_output_demux_control_test;
    import adc_demux_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, power_down_pin = 1'b0;
    logic [2:0] fold_msb_gray = 3'h0, fold_lsb_gray = 3'h0;
    logic [1:0] fold_mid_gray = 2'h0, s_axi_bresp, s_axi_rresp;
    logic output_mode_sel_first = 1'b1, output_mode_sel_second = 1'b0;
    logic sync_reset_p = 1'b0, sync_reset_n = 1'b1;
    logic [7:0] first_bank_bus, second_bank_bus, lvl_a, lvl_b, cur_bin = 8'h00, pg = 8'h00;
    logic first_bank_oe, second_bank_oe, output_strobe_p, output_strobe_n, output_strobe_oe, lvl_s;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmp_en = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, seed = 32'h0001_491E;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] sh [3], ea, eb, hd, w;
    logic es, ph;
    logic [16:0] exp_q [$];
    logic [33:0] rq [$];
    logic [1:0] bq [$];
    int n_errors = 0, total_checks = 0;

    // Clock stays at 25 MHz, well under the single-bank limit
    always #20 aclk = ~aclk;

    adc_output_demux_control u_dut (.aclk, .aresetn, .fold_msb_gray, .fold_mid_gray, .fold_lsb_gray,
        .output_mode_sel_first, .output_mode_sel_second, .power_down_pin, .sync_reset_p, .sync_reset_n,
        .first_bank_bus, .first_bank_oe, .second_bank_bus, .second_bank_oe,
        .output_strobe_p, .output_strobe_n, .output_strobe_oe,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    capture_rx_model u_rx (.aclk, .bank_a(first_bank_bus), .bank_b(second_bank_bus),
        .strobe(output_strobe_p), .oe(first_bank_oe & second_bank_oe & output_strobe_oe),
        .lvl_a, .lvl_b, .lvl_s);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Top bits of this sample, low bits of the one before
    task automatic step(input logic [7:0] b);
        logic [7:0] g;
        g = b ^ (b >> 1);
        @(posedge aclk);
        {fold_msb_gray, fold_mid_gray} <= g[7:3];
        fold_lsb_gray <= pg[2:0];
        cur_bin <= b;
        pg = g;
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // Expected bank contents, four edges behind the top bits
    always @(posedge aclk) begin
        w = sh[2];
        sh[2] = sh[1];
        sh[1] = sh[0];
        sh[0] = cur_bin;
        if (!aresetn) begin
            {ea, eb, hd, es, ph} = 26'h000_0000;
            sh = '{default: 8'h00};
        end else begin
            if (output_mode_sel_first) begin
                ea = w;
            end else if (output_mode_sel_second && ph) begin
                eb = w;
            end else if (output_mode_sel_second) begin
                ea = w;
            end else if (ph) begin
                ea = hd;
                eb = w;
            end else begin
                hd = w;
            end
            es = ph;
            ph = (sync_reset_p && !sync_reset_n) ? 1'b0 : !ph;
        end
        if (cmp_en) exp_q.push_back({ea, eb, es});
    end

    always @(negedge aclk) begin
        if (exp_q.size() > 0) check("banks", 34'(exp_q.pop_front()), 34'({lvl_a, lvl_b, lvl_s}));
    end

    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) check("read", rq.pop_front(), {s_axi_rdata, s_axi_rresp});
        if (s_axi_bvalid && s_axi_bready) check("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
    end

    initial begin
        logic [1:0] modes [4];
        modes = '{2'b10, 2'b01, 2'b00, 2'b11};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (modes[m]) begin
            // Stream keeps running so low bits stay paired with their top bits
            step(8'h00);
            {output_mode_sel_first, output_mode_sel_second} <= modes[m];
            sync_reset_p <= 1'b1;
            sync_reset_n <= 1'b0;
            step(8'h00);
            sync_reset_p <= 1'b0;
            sync_reset_n <= 1'b1;
            cmp_en <= 1'b1;
            for (int i = 0; i < 24; i++) begin
                seed = lfsr(seed);
                step(i == 0 ? 8'h00 : i == 1 ? 8'hFF : seed[7:0]);
                sync_reset_p <= (i == 13);
                sync_reset_n <= (i != 13);
            end
            cmp_en <= 1'b0;
        end
        repeat (2) step(8'h5A);
        // Resync held so the phase bit reads as zero
        power_down_pin <= 1'b1;
        sync_reset_p <= 1'b1;
        sync_reset_n <= 1'b0;
        @(negedge aclk);
        check("oe", 34'h0, 34'({first_bank_oe, second_bank_oe, output_strobe_oe}));
        @(posedge aclk);
        power_down_pin <= 1'b0;
        axi_wr(CTRL_OFFSET, 32'h0000_0001, RESP_OKAY);
        axi_rd(STATUS_OFFSET, {32'h0000_000A, RESP_OKAY});
        axi_wr(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        axi_rd(STATUS_OFFSET, {32'h0000_0002, RESP_OKAY});
        axi_rd(SAMPLE_OFFSET, {24'h00_0000, 8'h5A, RESP_OKAY});
        axi_rd(4'hC, {32'h0000_0000, RESP_SLVERR});
        axi_wr(4'hC, 32'h0000_0001, RESP_SLVERR);
        repeat (2) @(posedge aclk);
        end_sim;
    end

    // Watchdog, far beyond the expected run length
    initial begin
        repeat (1000) @(posedge aclk);
        n_errors++;
        end_sim;
    end
endmodule // adc_output_demux_control_test

bind adc_output_demux_control adc_demux_chk u_chk (.aclk, .aresetn, .output_mode_sel_first,
    .output_mode_sel_second, .power_down_pin, .sync_reset_p, .sync_reset_n, .first_bank_bus,
    .second_bank_bus, .first_bank_oe, .second_bank_oe, .output_strobe_p, .output_strobe_n, .output_strobe_oe);
